// ---- rtl/b3_defs.vh ----
`ifndef B3_DEFS_VH
`define B3_DEFS_VH

// ----------------------------------------------------------------------------
// PMIC state codes on pmicState
// ----------------------------------------------------------------------------
`define B3_PMIC_REGS_DISABLED 2'h0
`define B3_PMIC_RUN           2'h1
`define B3_PMIC_STANDBY       2'h2
`define B3_PMIC_SLEEP         2'h3

// ----------------------------------------------------------------------------
// Operating mode codes on modeCode_r
// ----------------------------------------------------------------------------
`define B3_MODE_OFF           2'h0
`define B3_MODE_ADAPTIVE      2'h1
`define B3_MODE_FORCED_PWM    2'h2
`define B3_MODE_LOW_POWER     2'h3

// ----------------------------------------------------------------------------
// Register indices on the read and write ports
// ----------------------------------------------------------------------------
`define B3_IDX_RUN_VOLTAGE     3'h0
`define B3_IDX_STANDBY_VOLTAGE 3'h1
`define B3_IDX_SLEEP_VOLTAGE   3'h2
`define B3_IDX_STATUS          3'h3
`define B3_IDX_MODE            3'h4

// ----------------------------------------------------------------------------
// Field positions of the status register
// ----------------------------------------------------------------------------
`define B3_STAT_HS_SENSE      0
`define B3_STAT_LS_SENSE      1
`define B3_STAT_HS_FAULT      2
`define B3_STAT_LS_FAULT      3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define B3_VOLTAGE_RESET      6'h00
`define B3_MODE_RESET         `B3_MODE_ADAPTIVE
`define B3_MILLIVOLT_RESET    12'h708

// ----------------------------------------------------------------------------
// Voltage code mapping, in millivolts
// ----------------------------------------------------------------------------
`define B3_MV_BASE            12'h708
`define B3_MV_STEP            12'h064

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define B3_CLK_KHZ            10000
`define B3_DEBOUNCE_US        8000
// Eight milliseconds of 100 ns cycles, sized to the counter width.
`define B3_DEBOUNCE_CYCLES    17'h13880
`define B3_DEBOUNCE_W         17

`endif

// ---- rtl/b3_debounce.v ----
`include "b3_defs.vh"

module b3_debounce #(
    parameter [`B3_DEBOUNCE_W-1:0] LIMIT = `B3_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // Raw fault level and debounced event
    input  wire faultLevel,
    output reg  firePulse_r
);

    reg [`B3_DEBOUNCE_W-1:0] count_r;
    reg [`B3_DEBOUNCE_W-1:0] count_nxt;

    // ------------------------------------------------------------------------
    // Persistence counter
    // ------------------------------------------------------------------------
    // A fault that drops out for even one cycle starts the wait again, so
    // only an uninterrupted fault can fire. The counter parks one past the
    // limit so a long fault fires exactly once.
    always @* begin
        count_nxt = count_r;
        if (!faultLevel) begin
            count_nxt = {`B3_DEBOUNCE_W{1'b0}};
        end else if (count_r <= LIMIT) begin
            count_nxt = count_r + {{(`B3_DEBOUNCE_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r     <= {`B3_DEBOUNCE_W{1'b0}};
            firePulse_r <= 1'b0;
        end else begin
            count_r     <= count_nxt;
            firePulse_r <= faultLevel && (count_r == LIMIT);
        end
    end

endmodule

// ---- rtl/b3_mode_ctrl.v ----
// Contract
// - In the off mode switching stops and the output discharge path is turned on.
// - Adaptive mode is the mode after reset, pulse skipping at light load and near-fixed frequency otherwise.
// - Forced PWM keeps fixed-frequency switching at every load and never skips pulses.
// - Adaptive mode picks DCM or CCM from load current, overridable by host control and standby or sleep changes.
// - Low-power mode lowers comparator bias and is only entered in standby or sleep with the low-power bit set.
// - Mode decodes from PMIC state and enable bits, with forced PWM winning over the low-power bit.
// - In run with low-power set and forced PWM clear the regulator stays adaptive, never low-power.
// - In standby or sleep, enabled, low-power set and forced PWM clear selects low-power mode.
// - Each FET is turned off as soon as its current passes its limit in that switching cycle.
// - A high-side or low-side limit hit raises its sense bit at once, with no debounce.
// - A current-limit status bit sets only after the fault has lasted longer than the 8.0 ms debounce.
// - Leaving the all-disabled state for run copies the fused code into the three voltage registers.
// - The run, standby and sleep voltage registers are read-only and ignore host writes.
// - The 4-bit code maps to 1.80 V plus 0.1 V per step up to 3.30 V.
`include "b3_defs.vh"

module b3_mode_ctrl #(
    parameter [`B3_DEBOUNCE_W-1:0] DEBOUNCE_CYCLES = `B3_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // PMIC state and host control bits
    input  wire [1:0]  pmicState,
    input  wire        buck3EnableBit,
    input  wire        buck3StandbyEnable,
    input  wire        buck3SleepOutputEnable,
    input  wire        buck3LowPowerSelect,
    input  wire        buck3ForceFixedFreq,
    input  wire        ccmForce,
    // Analog sense inputs
    input  wire        loadLight,
    input  wire        hsLimitHit,
    input  wire        lsLimitHit,
    // Fuse contents
    input  wire [5:0]  fusedBuck3VoltageCode,
    // Host register port
    input  wire        regRdEn,
    input  wire [2:0]  regRdIdx,
    input  wire        regWrEn,
    input  wire [2:0]  regWrIdx,
    input  wire [7:0]  regWrData,
    output reg  [7:0]  regRdData_r,
    output reg         regWrRefused_r,
    // Switching stage control
    output reg  [1:0]  modeCode_r,
    output reg         switchEnable_r,
    output reg         dischargeEnable_r,
    output reg         pulseSkipAllow_r,
    output reg         lowBias_r,
    output reg         hsGateOff_r,
    output reg         lsGateOff_r,
    // Fault flags
    output reg         hsSense_r,
    output reg         lsSense_r,
    output reg         hsFault_r,
    output reg         lsFault_r,
    // Voltage targets
    output reg  [5:0]  buck3RunVoltage_r,
    output reg  [5:0]  buck3StandbyVoltage_r,
    output reg  [5:0]  buck3SleepVoltage_r,
    output reg  [5:0]  activeVoltage_r,
    output reg  [11:0] targetMillivolt_r
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [1:0] decodeMode;
        input [1:0] state;
        input       en;
        input       stbyEn;
        input       slpEn;
        input       lowPwr;
        input       fpwm;
        reg         on;
        begin
            on = en;
            if (state == `B3_PMIC_REGS_DISABLED) begin
                on = 1'b0;
            end else if (state == `B3_PMIC_STANDBY && !stbyEn) begin
                on = 1'b0;
            end else if (state == `B3_PMIC_SLEEP && !slpEn) begin
                on = 1'b0;
            end
            if (!on) begin
                decodeMode = `B3_MODE_OFF;
            end else if (fpwm) begin
                decodeMode = `B3_MODE_FORCED_PWM;
            end else if (lowPwr && state != `B3_PMIC_RUN) begin
                decodeMode = `B3_MODE_LOW_POWER;
            end else begin
                decodeMode = `B3_MODE_ADAPTIVE;
            end
        end
    endfunction

    function [11:0] codeToMillivolt;
        input [3:0] code;
        begin
            codeToMillivolt = `B3_MV_BASE + `B3_MV_STEP * {8'h00, code};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    wire [1:0] modeNow = decodeMode(pmicState, buck3EnableBit, buck3StandbyEnable,
                                    buck3SleepOutputEnable, buck3LowPowerSelect,
                                    buck3ForceFixedFreq);

    reg  [1:0] prevState_r;
    wire       stateChange = (prevState_r != pmicState);
    wire       startUp     = (prevState_r == `B3_PMIC_REGS_DISABLED) && (pmicState == `B3_PMIC_RUN);

    reg        skip_nxt;

    // Any PMIC state change makes the adaptive-mode conduction choice restart in CCM
    // for one cycle, so the converter never carries a stale light-load
    // decision across a bias change.
    always @* begin
        skip_nxt = 1'b0;
        if (modeNow == `B3_MODE_ADAPTIVE) begin
            skip_nxt = loadLight && !ccmForce && !stateChange;
        end else if (modeNow == `B3_MODE_LOW_POWER) begin
            skip_nxt = loadLight;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prevState_r       <= `B3_PMIC_REGS_DISABLED;
            modeCode_r        <= `B3_MODE_RESET;
            switchEnable_r    <= 1'b0;
            dischargeEnable_r <= 1'b1;
            pulseSkipAllow_r  <= 1'b0;
            lowBias_r         <= 1'b0;
        end else begin
            prevState_r       <= pmicState;
            modeCode_r        <= modeNow;
            switchEnable_r    <= (modeNow != `B3_MODE_OFF);
            dischargeEnable_r <= (modeNow == `B3_MODE_OFF);
            pulseSkipAllow_r  <= skip_nxt;
            lowBias_r         <= (modeNow == `B3_MODE_LOW_POWER);
        end
    end

    // ------------------------------------------------------------------------
    // Current limit
    // ------------------------------------------------------------------------
    wire [1:0] limitHit = {lsLimitHit, hsLimitHit};
    wire [1:0] faultFire;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : gDebounce
            b3_debounce #(
                .LIMIT (DEBOUNCE_CYCLES)
            ) uDebounce (
                .clk_sys     (clk_sys),
                .rst_n       (rst_n),
                .faultLevel  (limitHit[gi]),
                .firePulse_r (faultFire[gi])
            );
        end
    endgenerate

    // Fault status is sticky; the host clears it by writing ones to the
    // status register, and a debounce event in that same cycle wins.
    wire       statusWr  = regWrEn && (regWrIdx == `B3_IDX_STATUS);
    wire       hsClear   = statusWr && regWrData[`B3_STAT_HS_FAULT];
    wire       lsClear   = statusWr && regWrData[`B3_STAT_LS_FAULT];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hsGateOff_r <= 1'b1;
            lsGateOff_r <= 1'b1;
            hsSense_r   <= 1'b0;
            lsSense_r   <= 1'b0;
            hsFault_r   <= 1'b0;
            lsFault_r   <= 1'b0;
        end else begin
            hsGateOff_r <= hsLimitHit || (modeNow == `B3_MODE_OFF);
            lsGateOff_r <= lsLimitHit || (modeNow == `B3_MODE_OFF);
            hsSense_r   <= hsLimitHit;
            lsSense_r   <= lsLimitHit;
            hsFault_r   <= faultFire[0] || (hsFault_r && !hsClear);
            lsFault_r   <= faultFire[1] || (lsFault_r && !lsClear);
        end
    end

    // ------------------------------------------------------------------------
    // Voltage registers
    // ------------------------------------------------------------------------
    reg [5:0] active_nxt;

    always @* begin
        case (pmicState)
            `B3_PMIC_STANDBY: active_nxt = buck3StandbyVoltage_r;
            `B3_PMIC_SLEEP:   active_nxt = buck3SleepVoltage_r;
            default:          active_nxt = buck3RunVoltage_r;
        endcase
    end

    // Host writes never reach these registers; only start-up loads them.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buck3RunVoltage_r     <= `B3_VOLTAGE_RESET;
            buck3StandbyVoltage_r <= `B3_VOLTAGE_RESET;
            buck3SleepVoltage_r   <= `B3_VOLTAGE_RESET;
            activeVoltage_r       <= `B3_VOLTAGE_RESET;
            targetMillivolt_r     <= `B3_MILLIVOLT_RESET;
        end else begin
            if (startUp) begin
                buck3RunVoltage_r     <= fusedBuck3VoltageCode;
                buck3StandbyVoltage_r <= fusedBuck3VoltageCode;
                buck3SleepVoltage_r   <= fusedBuck3VoltageCode;
            end
            activeVoltage_r   <= startUp ? fusedBuck3VoltageCode : active_nxt;
            targetMillivolt_r <= codeToMillivolt(startUp ? fusedBuck3VoltageCode[3:0] : active_nxt[3:0]);
        end
    end

    // ------------------------------------------------------------------------
    // Host register port
    // ------------------------------------------------------------------------
    reg [7:0] rd_nxt;
    wire      roWrite = regWrEn && (regWrIdx == `B3_IDX_RUN_VOLTAGE ||
                                    regWrIdx == `B3_IDX_STANDBY_VOLTAGE ||
                                    regWrIdx == `B3_IDX_SLEEP_VOLTAGE ||
                                    regWrIdx == `B3_IDX_MODE);

    always @* begin
        case (regRdIdx)
            `B3_IDX_RUN_VOLTAGE:     rd_nxt = {2'h0, buck3RunVoltage_r};
            `B3_IDX_STANDBY_VOLTAGE: rd_nxt = {2'h0, buck3StandbyVoltage_r};
            `B3_IDX_SLEEP_VOLTAGE:   rd_nxt = {2'h0, buck3SleepVoltage_r};
            `B3_IDX_STATUS:          rd_nxt = {4'h0, lsFault_r, hsFault_r, lsSense_r, hsSense_r};
            `B3_IDX_MODE:            rd_nxt = {6'h00, modeCode_r};
            default:                 rd_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_r    <= 8'h00;
            regWrRefused_r <= 1'b0;
        end else begin
            regRdData_r    <= regRdEn ? rd_nxt : 8'h00;
            regWrRefused_r <= roWrite;
        end
    end

endmodule

// ---- test/b3_mode_ctrl_properties.sv ----
`include "b3_defs.vh"
module b3_mode_ctrl_properties #(
    parameter [`B3_DEBOUNCE_W-1:0] DEBOUNCE_CYCLES = `B3_DEBOUNCE_CYCLES
) (
    // Clock, state and control bits
    input wire       clk_sys, rst_n,
    input wire [1:0] pmicState,
    input wire       buck3EnableBit, buck3SleepOutputEnable, buck3LowPowerSelect, buck3ForceFixedFreq,
    // Sense, fuse and write port
    input wire       hsLimitHit, lsLimitHit, regWrEn, regWrRefused_r,
    input wire [5:0] fusedBuck3VoltageCode,
    input wire [2:0] regWrIdx,
    // Outputs under watch
    input wire [1:0] modeCode_r,
    input wire       switchEnable_r, dischargeEnable_r, pulseSkipAllow_r, lowBias_r, hsGateOff_r, lsGateOff_r,
    input wire       hsSense_r, lsSense_r, hsFault_r, lsFault_r,
    input wire [5:0] buck3RunVoltage_r, buck3StandbyVoltage_r, buck3SleepVoltage_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ------------
    // Run lengths of each limit hit, in samples
    // ------------
    reg [17:0] hsCnt_r, lsCnt_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hsCnt_r <= 18'h00000;
            lsCnt_r <= 18'h00000;
        end else begin
            hsCnt_r <= hsLimitHit ? hsCnt_r + 18'h00001 : 18'h00000;
            lsCnt_r <= lsLimitHit ? lsCnt_r + 18'h00001 : 18'h00000;
        end
    end
    sequence startUp;
        pmicState == `B3_PMIC_REGS_DISABLED ##1 pmicState == `B3_PMIC_RUN;
    endsequence
    off_mode_a: assert property (!buck3EnableBit |=> modeCode_r == `B3_MODE_OFF && !switchEnable_r && dischargeEnable_r)
        else $error("regulator not off while disabled");
    fpwm_wins_a: assert property (pmicState == `B3_PMIC_RUN && buck3EnableBit && buck3ForceFixedFreq
        |=> modeCode_r == `B3_MODE_FORCED_PWM && !pulseSkipAllow_r) else $error("forced pwm not selected");
    run_no_lp_a: assert property (pmicState == `B3_PMIC_RUN && buck3EnableBit && buck3LowPowerSelect
        && !buck3ForceFixedFreq |=> modeCode_r == `B3_MODE_ADAPTIVE && !lowBias_r) else $error("low power in run");
    sleep_lp_a: assert property (pmicState == `B3_PMIC_SLEEP && buck3EnableBit && buck3SleepOutputEnable
        && buck3LowPowerSelect && !buck3ForceFixedFreq |=> modeCode_r == `B3_MODE_LOW_POWER && lowBias_r)
        else $error("low power not selected in sleep");
    sense_track_a: assert property (1 |=> hsSense_r == $past(hsLimitHit) && lsSense_r == $past(lsLimitHit))
        else $error("sense bit does not follow limit hit");
    gate_cut_a: assert property ((hsLimitHit |=> hsGateOff_r) and (lsLimitHit |=> lsGateOff_r))
        else $error("gate left on over limit");
    fault_wait_a: assert property (($rose(hsFault_r) |-> $past(hsCnt_r) > DEBOUNCE_CYCLES)
        and ($rose(lsFault_r) |-> $past(lsCnt_r) > DEBOUNCE_CYCLES)) else $error("fault set before debounce");
    fault_set_a: assert property ((hsCnt_r == DEBOUNCE_CYCLES + 1 |=> hsFault_r)
        and (lsCnt_r == DEBOUNCE_CYCLES + 1 |=> lsFault_r)) else $error("fault not set after debounce");
    startup_load_a: assert property (startUp |=> buck3RunVoltage_r == $past(fusedBuck3VoltageCode)
        && buck3StandbyVoltage_r == $past(fusedBuck3VoltageCode) && buck3SleepVoltage_r == $past(fusedBuck3VoltageCode))
        else $error("voltage codes not loaded at start-up");
    ro_write_a: assert property (regWrEn && regWrIdx <= `B3_IDX_SLEEP_VOLTAGE |=> regWrRefused_r
        && $stable(buck3RunVoltage_r) && $stable(buck3StandbyVoltage_r) && $stable(buck3SleepVoltage_r))
        else $error("voltage register changed by write");
endmodule
bind b3_mode_ctrl b3_mode_ctrl_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_b3_mode_ctrl_properties (
    .clk_sys, .rst_n, .pmicState, .buck3EnableBit, .buck3SleepOutputEnable, .buck3LowPowerSelect,
    .buck3ForceFixedFreq, .hsLimitHit, .lsLimitHit, .regWrEn, .regWrRefused_r, .fusedBuck3VoltageCode, .regWrIdx,
    .modeCode_r, .switchEnable_r, .dischargeEnable_r, .pulseSkipAllow_r, .lowBias_r, .hsGateOff_r, .lsGateOff_r,
    .hsSense_r, .lsSense_r, .hsFault_r, .lsFault_r, .buck3RunVoltage_r, .buck3StandbyVoltage_r, .buck3SleepVoltage_r
);

// ---- test/b3_host_model.sv ----
`include "b3_defs.vh"
module b3_host_model (
    // Clock
    input  wire       clk_sys,
    // Control bits set by the processor
    output reg  [1:0] pmicState,
    output reg        buck3EnableBit,
    output reg        buck3StandbyEnable,
    output reg        buck3SleepOutputEnable,
    output reg        buck3LowPowerSelect,
    output reg        buck3ForceFixedFreq,
    // Register port
    output reg        regRdEn,
    output reg  [2:0] regRdIdx,
    output reg        regWrEn,
    output reg  [2:0] regWrIdx,
    output reg  [7:0] regWrData,
    input  wire [7:0] regRdData_r,
    input  wire       regWrRefused_r
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pmicState = `B3_PMIC_REGS_DISABLED;
        {buck3EnableBit, buck3StandbyEnable, buck3SleepOutputEnable, buck3LowPowerSelect, buck3ForceFixedFreq} = 5'h00;
        {regRdEn, regRdIdx, regWrEn, regWrIdx, regWrData} = 16'h0000;
    end
    // Three cycles of settling, since pulse skipping is held off for one cycle after a state change.
    task setCtl(input logic [1:0] st, input logic [4:0] bits);
        @(posedge clk_sys);
        pmicState <= st;
        {buck3EnableBit, buck3StandbyEnable, buck3SleepOutputEnable, buck3LowPowerSelect, buck3ForceFixedFreq} <= bits;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task access(input logic wr, input logic [2:0] idx, input logic [7:0] data, output logic [7:0] rd,
                output logic refused);
        @(posedge clk_sys);
        regRdEn <= !wr;
        regWrEn <= wr;
        regRdIdx <= idx;
        regWrIdx <= idx;
        regWrData <= data;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        regWrEn <= 1'b0;
        #1 rd = regRdData_r;
        refused = regWrRefused_r;
    endtask
endmodule

// ---- test/buck3_mode_and_fault_control_bench.sv ----
`include "b3_defs.vh"
module buck3_mode_and_fault_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // A short debounce keeps the run brief; every current-limit expectation derives from it.
    localparam [`B3_DEBOUNCE_W-1:0] DEBOUNCE_N = 17'h00014;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         ccmForce = 1'b0;
    reg         loadLight = 1'b0;
    reg         hsLimitHit = 1'b0;
    reg         lsLimitHit = 1'b0;
    reg  [5:0]  fusedBuck3VoltageCode = 6'h00;
    wire [1:0]  pmicState, modeCode_r;
    wire        buck3EnableBit, buck3StandbyEnable, buck3SleepOutputEnable, buck3LowPowerSelect, buck3ForceFixedFreq;
    wire        regRdEn, regWrEn, regWrRefused_r, switchEnable_r, dischargeEnable_r, pulseSkipAllow_r, lowBias_r;
    wire        hsGateOff_r, lsGateOff_r, hsSense_r, lsSense_r, hsFault_r, lsFault_r;
    wire [2:0]  regRdIdx, regWrIdx;
    wire [7:0]  regWrData, regRdData_r;
    wire [5:0]  buck3RunVoltage_r, buck3StandbyVoltage_r, buck3SleepVoltage_r, activeVoltage_r;
    wire [11:0] targetMillivolt_r;
    logic [7:0] rd;
    logic       refused;
    int         errors = 0;
    int         n_compared = 0;
    b3_mode_ctrl #(.DEBOUNCE_CYCLES(DEBOUNCE_N)) u_b3_mode_ctrl (
        .clk_sys, .rst_n, .pmicState, .buck3EnableBit, .buck3StandbyEnable, .buck3SleepOutputEnable,
        .buck3LowPowerSelect, .buck3ForceFixedFreq, .ccmForce, .loadLight, .hsLimitHit, .lsLimitHit,
        .fusedBuck3VoltageCode, .regRdEn, .regRdIdx, .regWrEn, .regWrIdx, .regWrData, .regRdData_r,
        .regWrRefused_r, .modeCode_r, .switchEnable_r, .dischargeEnable_r, .pulseSkipAllow_r, .lowBias_r,
        .hsGateOff_r, .lsGateOff_r, .hsSense_r, .lsSense_r, .hsFault_r, .lsFault_r, .buck3RunVoltage_r,
        .buck3StandbyVoltage_r, .buck3SleepVoltage_r, .activeVoltage_r, .targetMillivolt_r
    );
    b3_host_model host (
        .clk_sys, .pmicState, .buck3EnableBit, .buck3StandbyEnable, .buck3SleepOutputEnable, .buck3LowPowerSelect,
        .buck3ForceFixedFreq, .regRdEn, .regRdIdx, .regWrEn, .regWrIdx, .regWrData, .regRdData_r, .regWrRefused_r
    );
    always #50 clk_sys = ~clk_sys;
    // ------------
    // Scenarios
    // ------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        n_compared++;
        if (seen !== expected) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, expected, seen);
        end
    endtask
    function automatic logic [1:0] expMode(input logic [1:0] st, input logic [4:0] b);
        if (st == `B3_PMIC_REGS_DISABLED || !b[4] || (st == `B3_PMIC_STANDBY && !b[3]) ||
            (st == `B3_PMIC_SLEEP && !b[2]))
            return `B3_MODE_OFF;
        if (b[0])
            return `B3_MODE_FORCED_PWM;
        if (b[1] && st != `B3_PMIC_RUN)
            return `B3_MODE_LOW_POWER;
        return `B3_MODE_ADAPTIVE;
    endfunction
    task testModes;
        logic [1:0] exp;
        @(posedge clk_sys) loadLight <= 1'b1;
        for (int i = 0; i < 128; i++) begin
            host.setCtl(i[6:5], i[4:0]);
            exp = expMode(i[6:5], i[4:0]);
            check("mode", modeCode_r, exp);
            check("switching", {switchEnable_r, dischargeEnable_r}, exp == `B3_MODE_OFF ? 2'h1 : 2'h2);
            check("low bias", lowBias_r, exp == `B3_MODE_LOW_POWER);
            check("pulse skip", pulseSkipAllow_r, exp == `B3_MODE_ADAPTIVE || exp == `B3_MODE_LOW_POWER);
        end
        @(posedge clk_sys) ccmForce <= 1'b1;
        host.setCtl(`B3_PMIC_RUN, 5'h10);
        check("forced ccm", pulseSkipAllow_r, 1'b0);
        @(posedge clk_sys) {ccmForce, loadLight} <= 2'h0;
        host.setCtl(`B3_PMIC_RUN, 5'h10);
        check("heavy load", pulseSkipAllow_r, 1'b0);
        $display("mode decode done");
    endtask
    task testStartup;
        for (int k = 0; k < 3; k++) begin
            host.setCtl(`B3_PMIC_REGS_DISABLED, 5'h10);
            @(posedge clk_sys) fusedBuck3VoltageCode <= 6'(6'h2f * k);
            host.setCtl(`B3_PMIC_RUN, 5'h10);
            for (int r = 0; r < 3; r++) begin
                host.access(1'b0, r[2:0], 8'h00, rd, refused);
                check("voltage code", rd, {2'h0, fusedBuck3VoltageCode});
            end
            check("active code", activeVoltage_r, fusedBuck3VoltageCode);
            check("millivolts", targetMillivolt_r, 12'h708 + 12'h064 * fusedBuck3VoltageCode[3:0]);
        end
        $display("start-up load done");
    endtask
    task testRegisters;
        for (int r = 0; r < 8; r++) begin
            host.access(1'b1, r[2:0], 8'hff, rd, refused);
            check("refused", refused, r <= 2 || r == 4);
        end
        for (int r = 0; r < 3; r++) begin
            host.access(1'b0, r[2:0], 8'h00, rd, refused);
            check("kept code", rd, {2'h0, fusedBuck3VoltageCode});
        end
        host.access(1'b0, 3'h6, 8'h00, rd, refused);
        check("unmapped", rd, 8'h00);
        host.access(1'b0, `B3_IDX_MODE, 8'h00, rd, refused);
        check("mode read", rd, {6'h00, `B3_MODE_ADAPTIVE});
        $display("register access done");
    endtask
    task holdHit(input int sel, input int n);
        @(posedge clk_sys);
        hsLimitHit <= sel == 0;
        lsLimitHit <= sel == 1;
        repeat (n - 1) @(posedge clk_sys);
        #1 check("sense", {lsSense_r, hsSense_r}, sel ? 2'h2 : 2'h1);
        check("gate off", {lsGateOff_r, hsGateOff_r}, sel ? 2'h2 : 2'h1);
        @(posedge clk_sys);
        hsLimitHit <= 1'b0;
        lsLimitHit <= 1'b0;
    endtask
    task testLimit(input int sel);
        host.setCtl(`B3_PMIC_RUN, 5'h10);
        holdHit(sel, DEBOUNCE_N);
        holdHit(sel, DEBOUNCE_N);
        repeat (2) @(posedge clk_sys);
        #1 check("early fault", {lsFault_r, hsFault_r}, 2'h0);
        holdHit(sel, DEBOUNCE_N + 1);
        repeat (2) @(posedge clk_sys);
        host.access(1'b0, `B3_IDX_STATUS, 8'h00, rd, refused);
        check("status", rd, sel ? 8'h08 : 8'h04);
        host.access(1'b1, `B3_IDX_STATUS, 8'h0c, rd, refused);
        host.access(1'b0, `B3_IDX_STATUS, 8'h00, rd, refused);
        check("cleared", rd, 8'h00);
        $display("current limit done");
    endtask
    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 check("reset mode", {modeCode_r, dischargeEnable_r}, {`B3_MODE_ADAPTIVE, 1'b1});
        @(posedge clk_sys) rst_n <= 1'b1;
        testModes;
        testStartup;
        testRegisters;
        testLimit(0);
        testLimit(1);
        print_verdict;
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        errors++;
        $display("watchdog expired");
        print_verdict;
    end
endmodule
